// ### dusc_host.sv
// host model: apb master and load strobe driver
`timescale 1ns/10ps
`default_nettype none
module dusc_host (
   input wire logic clk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic load_strobe_n
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      load_strobe_n = 1'b1;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines carry junk so a stale value never passes
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask
   // only called after a write frame has returned
   task pulse(input int n);
      @(posedge clk);
      load_strobe_n <= 1'b0;
      repeat (n) @(posedge clk);
      load_strobe_n <= 1'b1;
   endtask
   task level(input logic v);
      @(posedge clk);
      load_strobe_n <= v;
   endtask
endmodule
`default_nettype wire

// ### dusc_pkg.sv
// constants for the dac update and slew control block
package dusc_pkg;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CODE_W = 13;
   localparam int unsigned CLK_HZ = 10_000_000;

   // register byte addresses, channel index in addr[3:2]
   localparam logic [7:0] ADDR_TARGET_BASE = 8'h00;
   localparam logic [7:0] ADDR_CLEAR_BASE = 8'h10;
   localparam logic [7:0] ADDR_APPLIED_BASE = 8'h20;
   localparam logic [7:0] ADDR_SETUP_BASE = 8'h30;
   localparam logic [7:0] ADDR_CMD_KEY = 8'h40;
   localparam logic [7:0] ADDR_STATUS = 8'h44;

   // output_setup_reg fields, then the busy field position of the status register
   localparam int unsigned POS_CLEAR_ALLOW = 0;
   localparam int unsigned POS_SLEW_MODE = 1;
   localparam int unsigned POS_STEP_SEL = 3;
   localparam int unsigned POS_RATE_SEL = 5;
   localparam int unsigned SETUP_W = 7;
   localparam int unsigned POS_STAT_BUSY = 4;

   localparam logic [CODE_W-1:0] RST_CODE = 13'h0000;
   localparam logic [SETUP_W-1:0] RST_SETUP = 7'h00;

   localparam logic [15:0] KEY_CLEAR = 16'h73D1;
   localparam logic [15:0] KEY_LOAD = 16'h953A;

   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_LINEAR = 2'h1;
   localparam logic [1:0] MODE_HART = 2'h2;

   localparam logic [CODE_W-1:0] STEP_0 = 13'h0040;
   localparam logic [CODE_W-1:0] STEP_1 = 13'h0078;
   localparam logic [CODE_W-1:0] STEP_2 = 13'h01F4;
   localparam logic [CODE_W-1:0] STEP_3 = 13'h071C;

   localparam int unsigned RATE_0_KHZ = 4;
   localparam int unsigned RATE_1_KHZ = 64;
   localparam int unsigned RATE_2_KHZ = 150;
   localparam int unsigned RATE_3_KHZ = 240;
   localparam int unsigned DIV_W = 12;
   localparam logic [DIV_W-1:0] RATE_0_DIV = DIV_W'(CLK_HZ / (RATE_0_KHZ * 1000));
   localparam logic [DIV_W-1:0] RATE_1_DIV = DIV_W'(CLK_HZ / (RATE_1_KHZ * 1000));
   localparam logic [DIV_W-1:0] RATE_2_DIV = DIV_W'(CLK_HZ / (RATE_2_KHZ * 1000));
   localparam logic [DIV_W-1:0] RATE_3_DIV = DIV_W'(CLK_HZ / (RATE_3_KHZ * 1000));

   // hart mode: smallest step at the slowest rate
   localparam logic [CODE_W-1:0] HART_STEP = STEP_0;
   localparam logic [DIV_W-1:0] HART_DIV = RATE_0_DIV;
endpackage

// ### dusc_slew.sv
// per-channel linear slew engine holding the code applied to one dac
`timescale 1ns/10ps
`default_nettype none
module dusc_slew (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [12:0] load_val,
   input wire logic [1:0] mode,
   input wire logic [1:0] step_sel,
   input wire logic [1:0] rate_sel,
   output logic [12:0] code,
   output logic busy
);
   logic [12:0] code_q, code_d, goal_q, goal_d, step, diff;
   logic [11:0] cnt_q, cnt_d, div;
   logic busy_q, busy_d;

   always_comb begin
      if (mode == dusc_pkg::MODE_HART) begin
         step = dusc_pkg::HART_STEP; // RULE19
         div = dusc_pkg::HART_DIV;
      end else begin
         unique case (step_sel) // RULE14
            2'h0: step = dusc_pkg::STEP_0;
            2'h1: step = dusc_pkg::STEP_1;
            2'h2: step = dusc_pkg::STEP_2;
            2'h3: step = dusc_pkg::STEP_3;
         endcase
         unique case (rate_sel) // RULE15
            2'h0: div = dusc_pkg::RATE_0_DIV;
            2'h1: div = dusc_pkg::RATE_1_DIV;
            2'h2: div = dusc_pkg::RATE_2_DIV;
            2'h3: div = dusc_pkg::RATE_3_DIV;
         endcase
      end
      diff = (goal_q > code_q) ? goal_q - code_q : code_q - goal_q;
   end

   always_comb begin
      code_d = code_q;
      goal_d = goal_q;
      busy_d = busy_q;
      cnt_d = cnt_q;
      if (load) begin
         goal_d = load_val;
         cnt_d = 12'h000;
         if (mode == dusc_pkg::MODE_OFF) begin
            code_d = load_val; // RULE13
            busy_d = 1'b0;
         end else begin
            busy_d = (load_val != code_q);
         end
      end else if (busy_q) begin
         if (cnt_q >= div - 12'h001) begin
            cnt_d = 12'h000;
            // never overshoot: last increment lands on the goal
            if (diff <= step) begin
               code_d = goal_q; // RULE20
               busy_d = 1'b0;
            end else if (goal_q > code_q) begin
               code_d = code_q + step; // RULE14
            end else begin
               code_d = code_q - step; // RULE14
            end
         end else begin
            cnt_d = cnt_q + 12'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code_q <= dusc_pkg::RST_CODE;
         goal_q <= dusc_pkg::RST_CODE;
         busy_q <= 1'b0;
         cnt_q <= 12'h000;
      end else begin
         code_q <= code_d;
         goal_q <= goal_d;
         busy_q <= busy_d;
         cnt_q <= cnt_d;
      end
   end

   // each increment also lands in the applied code register
   assign code = code_q; // RULE17
   assign busy = busy_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_SINGLE_STEP: assert property (load && mode == dusc_pkg::MODE_OFF |=> code_q == $past(load_val) && !busy_q) // RULE13
      else $error("slew off load did not apply in one step");
   AST_STEP_LIMIT: assert property (!load && busy_q && code_q != code_d // RULE14
      |-> code_d == goal_q || code_d == code_q + step || code_d == code_q - step)
      else $error("slew moved by other than the step");
   AST_TICK_GAP: assert property (!load && busy_q && code_d != code_q |-> cnt_q == div - 12'h001) // RULE15
      else $error("slew increment off the rate tick");
   AST_NO_OVERSHOOT: assert property (!load && busy_q && diff <= step && cnt_q == div - 12'h001 |=> code_q == goal_q && !busy_q) // RULE20
      else $error("slew final increment missed the goal");
endmodule
`default_nettype wire

// ### dusc_top.sv
// dac update, clear and slew control with apb register access
//
// Summary of operation
// RULE1: each dac code comes from target, clear value, or the slew engine
// RULE2: command key 0x73D1 loads clear value into channels allowing clear
// RULE3: applied code register always holds the code currently at the dac
// RULE4: strobe high holds written codes pending; strobe low or key 0x953A applies
// RULE5: host pulses strobe only after the target code write completes
// RULE6: strobe held low applies each written code right after the write
// RULE7: applied code register updates in the cycle the dac code changes
// RULE8: clear only touches channels whose clear_allow bit is set
// RULE9: a 13-bit clear value per channel is the clear target
// RULE10: on clear the applied code updates with the dac code
// RULE11: clear wins over a pending strobe-driven update
// RULE12: host rewrites target after clear; no automatic restore
// RULE13: slew off applies the target in a single step
// RULE14: slew on moves by 64, 120, 500 or 1820 codes per increment
// RULE15: increments occur at 4, 64, 150 or 240 kHz
// RULE16: slew available on every channel for current and voltage output
// RULE17: applied code register updates on every slew increment
// RULE18: clear with slew enabled ramps to the clear value
// RULE19: per-channel mode field selects a hart-compatible slew
// RULE20: final increment loads the target exactly, never overshooting
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dusc_top (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LOAD_STROBE_N,
   output logic [12:0] DAC_CODE_0,
   output logic [12:0] DAC_CODE_1,
   output logic [12:0] DAC_CODE_2,
   output logic [12:0] DAC_CODE_3
);
   localparam int unsigned NCH = dusc_pkg::NUM_CH;

   logic [12:0] target_q [NCH];
   logic [12:0] target_d [NCH];
   logic [12:0] clear_q [NCH];
   logic [12:0] clear_d [NCH];
   logic [6:0] setup_q [NCH];
   logic [6:0] setup_d [NCH];
   logic [NCH-1:0] pending_q, pending_d;
   logic [NCH-1:0] ch_load, ch_busy, clr_allow;
   logic [NCH-1:0] tgt_wr;
   logic [12:0] ch_val [NCH];
   logic [12:0] applied [NCH];
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic wr_en, clear_key_wr, load_key_wr;
   logic [1:0] idx;
   logic strobe_s1_q, strobe_s2_q, strobe_s3_q, strobe_lvl_q, strobe_lvl_d;

   // unaligned writes are refused, as the error flag reports
   assign wr_en = PSEL && PENABLE && PWRITE && PADDR[1:0] == 2'h0;
   assign idx = PADDR[3:2];
   assign clear_key_wr = wr_en && PADDR == dusc_pkg::ADDR_CMD_KEY && PWDATA[15:0] == dusc_pkg::KEY_CLEAR;
   assign load_key_wr = wr_en && PADDR == dusc_pkg::ADDR_CMD_KEY && PWDATA[15:0] == dusc_pkg::KEY_LOAD;

   // strobe pin: three flops, level accepted when the last two agree
   assign strobe_lvl_d = (strobe_s2_q == strobe_s3_q) ? strobe_s3_q : strobe_lvl_q;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         strobe_s1_q <= 1'b1;
         strobe_s2_q <= 1'b1;
         strobe_s3_q <= 1'b1;
         strobe_lvl_q <= 1'b1;
      end else begin
         strobe_s1_q <= LOAD_STROBE_N;
         strobe_s2_q <= strobe_s1_q;
         strobe_s3_q <= strobe_s2_q;
         strobe_lvl_q <= strobe_lvl_d;
      end
   end

   // register writes and the per-channel source select
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         target_d[i] = target_q[i];
         clear_d[i] = clear_q[i];
         setup_d[i] = setup_q[i];
         tgt_wr[i] = wr_en && PADDR[7:4] == dusc_pkg::ADDR_TARGET_BASE[7:4] && idx == 2'(i);
         clr_allow[i] = setup_q[i][dusc_pkg::POS_CLEAR_ALLOW];
         if (tgt_wr[i]) begin
            target_d[i] = PWDATA[12:0];
         end
         if (wr_en && PADDR[7:4] == dusc_pkg::ADDR_CLEAR_BASE[7:4] && idx == 2'(i)) begin
            clear_d[i] = PWDATA[12:0]; // RULE9
         end
         if (wr_en && PADDR[7:4] == dusc_pkg::ADDR_SETUP_BASE[7:4] && idx == 2'(i)) begin
            setup_d[i] = PWDATA[6:0];
         end
         pending_d[i] = pending_q[i];
         ch_load[i] = 1'b0;
         ch_val[i] = target_q[i];
         if (clear_key_wr && clr_allow[i]) begin
            // clear beats strobe; the old target is dropped for good
            ch_load[i] = 1'b1; // RULE2 RULE11 RULE18
            ch_val[i] = clear_q[i]; // RULE1 RULE8
            pending_d[i] = 1'b0; // RULE12
         end else if (pending_q[i] && (load_key_wr || !strobe_lvl_q)) begin
            ch_load[i] = 1'b1; // RULE4 RULE6
            pending_d[i] = 1'b0;
         end
         // a write landing with its own apply keeps the new value pending
         if (tgt_wr[i]) begin
            pending_d[i] = 1'b1; // RULE4
         end
      end
   end

   // read data captured in the setup phase so it sits in a flop
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (PSEL && !PENABLE) begin
         prdata_d = 32'h0000_0000;
         pslverr_d = 1'b0;
         unique case (PADDR[7:4])
            dusc_pkg::ADDR_TARGET_BASE[7:4]: prdata_d[12:0] = target_q[idx];
            dusc_pkg::ADDR_CLEAR_BASE[7:4]: prdata_d[12:0] = clear_q[idx];
            dusc_pkg::ADDR_APPLIED_BASE[7:4]: prdata_d[12:0] = applied[idx]; // RULE3
            dusc_pkg::ADDR_SETUP_BASE[7:4]: prdata_d[6:0] = setup_q[idx];
            dusc_pkg::ADDR_CMD_KEY[7:4]: begin
               if (PADDR == dusc_pkg::ADDR_STATUS) begin
                  prdata_d[7:0] = {ch_busy, pending_q};
               end else if (PADDR != dusc_pkg::ADDR_CMD_KEY) begin
                  pslverr_d = 1'b1;
               end
            end
            default: pslverr_d = 1'b1;
         endcase
         if (PADDR[1:0] != 2'h0) begin
            pslverr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         for (int i = 0; i < NCH; i++) begin
            target_q[i] <= dusc_pkg::RST_CODE;
            clear_q[i] <= dusc_pkg::RST_CODE;
            setup_q[i] <= dusc_pkg::RST_SETUP;
         end
         pending_q <= '0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         target_q <= target_d;
         clear_q <= clear_d;
         setup_q <= setup_d;
         pending_q <= pending_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // one engine per channel, same for current and voltage output
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      dusc_slew u_slew ( // RULE16
         .clk(CLK_SYS),
         .rst_n(RST_N),
         .load(ch_load[g]),
         .load_val(ch_val[g]),
         .mode(setup_q[g][dusc_pkg::POS_SLEW_MODE +: 2]), // RULE19
         .step_sel(setup_q[g][dusc_pkg::POS_STEP_SEL +: 2]),
         .rate_sel(setup_q[g][dusc_pkg::POS_RATE_SEL +: 2]),
         .code(applied[g]),
         .busy(ch_busy[g])
      );
   end

   // dac and applied code share one flop, so they never differ
   assign DAC_CODE_0 = applied[0]; // RULE7 RULE10
   assign DAC_CODE_1 = applied[1];
   assign DAC_CODE_2 = applied[2];
   assign DAC_CODE_3 = applied[3];
   assign PREADY = 1'b1;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_wr2_strobe_low;
      tgt_wr[2] && !strobe_lvl_q && !clear_key_wr;
   endsequence
   sequence s_held_low;
      !strobe_lvl_q && !clear_key_wr;
   endsequence

   AST_CLEAR_LOAD: assert property (clear_key_wr && clr_allow[0] |-> ch_load[0] && ch_val[0] == clear_q[0]) // RULE2
      else $error("clear key did not load clear value");
   AST_CLEAR_BLOCKED: assert property (clear_key_wr && !clr_allow[1] && !pending_q[1] && !ch_busy[1] // RULE8
      |=> DAC_CODE_1 == $past(DAC_CODE_1))
      else $error("clear moved a channel without clear_allow");
   AST_HOLD_PENDING: assert property (tgt_wr[1] ##1 (strobe_lvl_q && !load_key_wr && !clear_key_wr) [*3] |-> pending_q[1]) // RULE4
      else $error("pending code applied without a trigger");
   AST_AUTO_APPLY: assert property (s_wr2_strobe_low ##1 s_held_low |-> ch_load[2] && ch_val[2] == target_q[2]) // RULE6
      else $error("strobe low did not apply the written code");
   AST_LOAD_KEY: assert property (load_key_wr && pending_q[0] && !clear_key_wr // RULE4
      && setup_q[0][dusc_pkg::POS_SLEW_MODE +: 2] == dusc_pkg::MODE_OFF |=> DAC_CODE_0 == $past(target_q[0]))
      else $error("load key did not apply pending code");
   AST_CLEAR_PRIO: assert property (clear_key_wr && clr_allow[0] && pending_q[0] // RULE11
      |-> ch_val[0] == clear_q[0] ##1 !pending_q[0])
      else $error("pending update beat the clear");
   AST_NO_RESTORE: assert property (clear_key_wr && clr_allow[0] && !tgt_wr[0] |=> !pending_q[0]) // RULE12
      else $error("pre-clear code left pending after clear");
   AST_APPLIED_TRACKS: assert property ($changed(DAC_CODE_1) |-> $past(ch_load[1] || ch_busy[1])) // RULE7
      else $error("dac code changed without an update");
   AST_STROBE_FILTER: assert property (strobe_s2_q == strobe_s3_q |=> strobe_lvl_q == $past(strobe_s3_q))
      else $error("strobe level not taken when filter stages agree");
   AST_STROBE_HOLD: assert property (strobe_s2_q != strobe_s3_q |=> strobe_lvl_q == $past(strobe_lvl_q))
      else $error("strobe level moved while filter stages disagree");
   AST_PEND_SET: assert property (tgt_wr[2] |=> pending_q[2]) // RULE4
      else $error("target write did not leave the code pending");
   AST_CLEAR_VALUE: assert property (clear_key_wr && clr_allow[0] // RULE10
      && setup_q[0][dusc_pkg::POS_SLEW_MODE +: 2] == dusc_pkg::MODE_OFF |=> DAC_CODE_0 == $past(clear_q[0]))
      else $error("clear value not at the dac after clear");
   AST_CLEAR_SLEW: assert property (clear_key_wr && clr_allow[3] && clear_q[3] != DAC_CODE_3 // RULE18
      && setup_q[3][dusc_pkg::POS_SLEW_MODE +: 2] != dusc_pkg::MODE_OFF
      |=> ch_busy[3] && DAC_CODE_3 == $past(DAC_CODE_3))
      else $error("clear with slew on jumped instead of ramping");
   AST_APPLIED_READ: assert property (PSEL && !PENABLE && PADDR == dusc_pkg::ADDR_APPLIED_BASE // RULE3
      |=> PRDATA[12:0] == $past(DAC_CODE_0))
      else $error("applied code readback differs from the dac code");
   AST_SLEW_TRACKS: assert property ($changed(DAC_CODE_3) |-> $past(ch_load[3] || ch_busy[3])) // RULE17
      else $error("dac code moved outside a load or a slew");
endmodule
`default_nettype wire

// ### dusc_top_tb.sv
// self-checking bench for the dac update and slew control block
`timescale 1ns/10ps
`default_nettype none
module dusc_top_tb;
   localparam logic [7:0] TGT = dusc_pkg::ADDR_TARGET_BASE;
   localparam logic [7:0] CLR = dusc_pkg::ADDR_CLEAR_BASE;
   localparam logic [7:0] APL = dusc_pkg::ADDR_APPLIED_BASE;
   localparam logic [7:0] SET = dusc_pkg::ADDR_SETUP_BASE;
   localparam logic [7:0] KEY = dusc_pkg::ADDR_CMD_KEY;
   localparam logic [7:0] STA = dusc_pkg::ADDR_STATUS;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, load_strobe_n, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] dac [4];
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #50 clk_sys = ~clk_sys;
   dusc_host h (.clk(clk_sys), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .load_strobe_n(load_strobe_n));
   dusc_top uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LOAD_STROBE_N(load_strobe_n), .DAC_CODE_0(dac[0]), .DAC_CODE_1(dac[1]), .DAC_CODE_2(dac[2]),
      .DAC_CODE_3(dac[3]));
   task results;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      h.xfer(1'b0, a, 32'h00000000, rd, er);
      chk(n, rd, e);
   endtask
   // waits out each increment; the first gap depends on load latency, so it is not timed
   task slew(input logic [12:0] from, input logic [12:0] goal, input logic [12:0] step,
      input logic [11:0] div, input int n);
      logic [12:0] e;
      int c;
      e = from;
      for (int i = 0; i < n; i++) begin
         c = 0;
         while (dac[3] === e && c < 3000) begin
            @(negedge clk_sys);
            c++;
         end
         if (goal > e)
            e = (goal - e > step) ? e + step : goal;
         else
            e = (e - goal > step) ? e - step : goal;
         chk("slew code", dac[3], e);
         if (i > 0)
            chk("slew gap", c, {20'h0, div});
      end
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdchk("applied 0", APL, 32'h0);
      h.wr(TGT, 32'h1ABC);
      repeat (4) @(negedge clk_sys);
      chk("held dac 0", dac[0], 32'h0);
      rdchk("pending", STA, 32'h1);
      h.wr(KEY, {16'h0, dusc_pkg::KEY_LOAD});
      repeat (3) @(negedge clk_sys);
      chk("key dac 0", dac[0], 32'h1ABC);
      rdchk("applied 0", APL, 32'h1ABC);
      h.wr(TGT + 8'h04, 32'h0555);
      repeat (8) @(negedge clk_sys);
      chk("held dac 1", dac[1], 32'h0);
      h.pulse(5);
      repeat (8) @(negedge clk_sys);
      chk("strobe dac 1", dac[1], 32'h0555);
      h.wr(SET, 32'h1);
      h.wr(SET + 8'h04, 32'h0);
      h.wr(CLR, 32'h0AAA);
      h.wr(CLR + 8'h04, 32'h1111);
      h.wr(TGT, 32'h0123);
      h.wr(KEY, {16'h0, dusc_pkg::KEY_CLEAR});
      repeat (3) @(negedge clk_sys);
      chk("clear dac 0", dac[0], 32'h0AAA);
      chk("kept dac 1", dac[1], 32'h0555);
      rdchk("applied 0", APL, 32'h0AAA);
      rdchk("pending", STA, 32'h0);
      h.level(1'b0);
      repeat (8) @(negedge clk_sys);
      chk("no restore dac 0", dac[0], 32'h0AAA);
      // strobe now low: a write goes straight through
      h.wr(TGT + 8'h08, 32'h0F0F);
      @(negedge clk_sys);
      chk("early dac 2", dac[2], 32'h0);
      @(negedge clk_sys);
      chk("direct dac 2", dac[2], 32'h0F0F);
      h.xfer(1'b0, 8'h48, 32'h0, rd, er);
      chk("unmapped err", {31'h0, er}, 32'h1);
      h.wr(SET + 8'h0C, 32'h7A);
      h.wr(TGT + 8'h0C, 32'h1FFF);
      rdchk("busy", STA, 32'h80);
      slew(13'h0000, 13'h1FFF, dusc_pkg::STEP_3, dusc_pkg::RATE_3_DIV, 5);
      rdchk("applied 3", APL + 8'h0C, 32'h1FFF);
      h.wr(CLR + 8'h0C, 32'h0);
      h.wr(SET + 8'h0C, 32'h7B);
      h.wr(KEY, {16'h0, dusc_pkg::KEY_CLEAR});
      slew(13'h1FFF, 13'h0000, dusc_pkg::STEP_3, dusc_pkg::RATE_3_DIV, 5);
      h.wr(SET + 8'h0C, 32'h04);
      h.wr(TGT + 8'h0C, 32'h0080);
      slew(13'h0000, 13'h0080, dusc_pkg::HART_STEP, dusc_pkg::HART_DIV, 2);
      results();
   end
endmodule
`default_nettype wire
